// ===== verilog/pwm_fade_pkg.sv
// Purpose: Shared constants and types for the detection PWM fade block
// Assumes: 200 MHz system clock, byte-wide command link
// Notes:   Time settings are 14 bits, duties are whole percent codes
package pwm_fade_pkg;

  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned PWM_STEPS    = 100;
  localparam int unsigned FREQ_CODES   = 10;
  localparam int unsigned FREQ_UNIT_HZ = 1000;

  localparam int unsigned DUTY_W  = 7;
  localparam int unsigned TIME_W  = 14;
  localparam int unsigned LOW_W   = 7;
  localparam int unsigned STEP_W  = 11;
  localparam int unsigned ACC_W   = 21;
  localparam int unsigned SEC_W   = 10;
  localparam int unsigned ADC_W   = 12;
  localparam int unsigned PROD_W  = 19;

  localparam logic [7:0] ADDR_FLAG        = 8'h80;
  localparam logic [7:0] ADDR_COND        = 8'hA0;
  localparam logic [7:0] ADDR_INVERSE     = 8'hA1;
  localparam logic [7:0] ADDR_FREQ        = 8'hA3;
  localparam logic [7:0] ADDR_IDLE_DUTY   = 8'hA4;
  localparam logic [7:0] ADDR_ACTIVE_DUTY = 8'hA5;
  localparam logic [7:0] ADDR_UP_HIGH     = 8'hA6;
  localparam logic [7:0] ADDR_UP_LOW      = 8'hA7;
  localparam logic [7:0] ADDR_DOWN_HIGH   = 8'hA8;
  localparam logic [7:0] ADDR_DOWN_LOW    = 8'hA9;
  localparam logic [7:0] ADDR_LINGER_HIGH = 8'hAA;
  localparam logic [7:0] ADDR_LINGER_LOW  = 8'hAB;
  localparam logic [7:0] ADDR_PIN_SENS    = 8'hB0;
  localparam logic [7:0] ADDR_READ        = 8'hFF;

  localparam logic [6:0]  DUTY_MAX        = 7'h64;
  localparam logic [6:0]  IDLE_DUTY_RST   = 7'h00;
  localparam logic [6:0]  ACTIVE_DUTY_RST = 7'h5A;
  localparam logic [13:0] RAMP_UP_RST     = 14'h03E8;
  localparam logic [13:0] RAMP_DOWN_RST   = 14'h03E8;
  localparam logic [13:0] LINGER_RST      = 14'h000A;
  localparam logic [3:0]  FREQ_RST        = 4'h4;
  localparam logic [3:0]  FREQ_MAX        = 4'h9;
  localparam logic [1:0]  COND_BOTH       = 2'h0;
  localparam logic [1:0]  COND_APPROACH   = 2'h1;
  localparam logic [1:0]  COND_LEAVE      = 2'h2;
  localparam logic [1:0]  COND_MAX        = 2'h2;
  localparam logic [PROD_W-1:0] SENS_SCALE = 19'h00065;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h01,
    ST_RAMP_UP   = 5'h02,
    ST_ACTIVE    = 5'h04,
    ST_LINGER    = 5'h08,
    ST_RAMP_DOWN = 5'h10
  } fade_state_e;

endpackage

// ===== verilog/pulse_divider.sv
// Purpose: One-cycle tick every DIVIDE enabled clocks
// Assumes: DIVIDE of at least two
// Notes:   Used for the millisecond time base of fades and hold
`timescale 1ns/1ps
module pulse_divider
  import pwm_fade_pkg::*;
#(
  parameter int unsigned DIVIDE = MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  output logic      tick
);
  localparam int unsigned CNT_W = $clog2(DIVIDE);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIVIDE - 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } div_s;

  div_s cur;
  div_s next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (cur.count == LAST) begin
      next_cur.count = '0;
      next_cur.tick  = 1'b1;
    end else begin
      next_cur.count = cur.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule

// ===== verilog/pwm_wave.sv
// Purpose: PWM waveform with a period of one hundred percent slots
// Assumes: step_cycles is the clock count of one percent slot
// Notes:   Duty and slot width are taken only at a period start,
//          so a change never produces a runt pulse
`timescale 1ns/1ps
module pwm_wave
  import pwm_fade_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              enable,
  input  wire logic [STEP_W-1:0] step_cycles,
  input  wire logic [DUTY_W-1:0] duty,
  output logic                   wave
);
  localparam logic [DUTY_W-1:0] LAST_SLOT = DUTY_W'(PWM_STEPS - 1);

  typedef struct packed {
    logic [STEP_W-1:0] sub;
    logic [DUTY_W-1:0] slot;
    logic [STEP_W-1:0] step;
    logic [DUTY_W-1:0] level;
    logic              wave;
  } wave_s;

  wave_s cur;
  wave_s next_cur;

  always_comb begin
    next_cur = cur;
    if (cur.sub + 1'b1 >= cur.step) begin
      next_cur.sub = '0;
      if (cur.slot == LAST_SLOT) begin
        next_cur.slot  = '0;
        next_cur.step  = step_cycles;
        next_cur.level = duty;
      end else begin
        next_cur.slot = cur.slot + 1'b1;
      end
    end else begin
      next_cur.sub = cur.sub + 1'b1;
    end
    next_cur.wave = enable && (next_cur.slot < next_cur.level);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur      <= '0;
      cur.step <= step_cycles_rst();
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // Reset slot width follows the reset frequency code, else the first
  // period after reset would run at the fastest carrier
  function automatic logic [STEP_W-1:0] step_cycles_rst();
    return STEP_W'(CLK_HZ /
                   ((int'(FREQ_RST) + 1) * FREQ_UNIT_HZ * PWM_STEPS));
  endfunction

  assign wave = cur.wave;
endmodule

// ===== verilog/detection_pwm_fade_control.sv
// Purpose: Detection-driven PWM with fade in, hold and fade out
// Assumes: Command bytes, detect flags and sensor code are synchronous
// Notes:   Registered outputs; times are 14-bit values
// Operation
// R1: No detection drives idle duty, 0..100%
// R2: Detection drives active duty, 0..100%
// R3: Active duty resets to 90 percent
// R4: Fade in over programmed milliseconds
// R5: Fade in resets to 1000 ms
// R6: After hold, fade out to idle duty
// R7: Hold active duty programmed seconds, default 10
// R8: Times split high>>7 and low&0x7F
// R9: Compute pin sensitivity percent into status
// R10: Enabled option applies pin sensitivity both ways
// R11: Pin sensitivity refreshes even when disabled
// R12: Sensitivity status is read only
// R13: Duties only in PWM mode; 1-10 kHz
// R14: Judge detection by condition setting
// R15: Inverse flips judged detection before duty
// R16: Address byte MSB set, parameter MSB clear
// R17: Linear fade steps once per millisecond
`timescale 1ns/1ps
module detection_pwm_fade_control
  import pwm_fade_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             cmd_valid,
  input  wire logic [7:0]       cmd_byte,
  input  wire logic             approach_detect,
  input  wire logic             leave_detect,
  input  wire logic             pwm_mode,
  input  wire logic             analog_sens_enable,
  input  wire logic [ADC_W-1:0] sens_pin_level,
  input  wire logic [6:0]       manual_sensitivity,
  output logic                  motion_output_pin,
  output logic                  resp_valid,
  output logic [7:0]            resp_data,
  output logic                  cmd_error,
  output logic [DUTY_W-1:0]     current_duty,
  output logic [6:0]            approach_sensitivity,
  output logic [6:0]            leave_sensitivity
);

  // All control state in one record, registered as a whole
  typedef struct packed {
    fade_state_e       state;
    logic [6:0]        idle_duty;
    logic [6:0]        active_duty;
    logic [13:0]       ramp_up;
    logic [13:0]       ramp_down;
    logic [13:0]       linger;
    logic [3:0]        freq;
    logic [1:0]        cond;
    logic              inverse;
    logic              have_addr;
    logic [7:0]        addr;
    logic [6:0]        duty;
    logic [6:0]        goal;
    logic [6:0]        delta;
    logic [13:0]       span;
    logic [13:0]       elapsed;
    logic [ACC_W-1:0]  acc;
    logic [SEC_W-1:0]  ms_in_s;
    logic [13:0]       secs;
    logic [6:0]        pin_sens;
    logic [6:0]        approach_sens;
    logic [6:0]        leave_sens;
    logic              resp_valid;
    logic [7:0]        resp_data;
    logic              cmd_error;
    logic [STEP_W-1:0] step_cycles;
  } ctrl_s;

  localparam logic [SEC_W-1:0] LAST_MS = SEC_W'(MS_PER_S - 1);
  // Slot width of the reset frequency code
  localparam logic [STEP_W-1:0] RST_STEP =
    STEP_W'(CLK_HZ / ((int'(FREQ_RST) + 1) * FREQ_UNIT_HZ * PWM_STEPS));

  ctrl_s                    cur;
  ctrl_s                    next_cur;
  logic                     ms_tick;
  logic                     det_raw;
  logic                     det;
  logic [PROD_W-1:0]        sens_prod;
  logic [STEP_W-1:0]        step_tab [FREQ_CODES];

  // Percent slot width per frequency code, 1 kHz upward in 1 kHz steps
  for (genvar g = 0; g < FREQ_CODES; g++) begin : g_step
    assign step_tab[g] =
      STEP_W'(CLK_HZ / ((g + 1) * FREQ_UNIT_HZ * PWM_STEPS));
  end

  // Millisecond time base shared by fades and hold
  pulse_divider #(
    .DIVIDE (TICK_CYCLES)
  ) u_ms_tick (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .tick  (ms_tick)
  );

  // R13: pwm mode only
  pwm_wave u_wave (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .enable      (pwm_mode),
    .step_cycles (cur.step_cycles),
    .duty        (cur.duty),
    .wave        (motion_output_pin)
  );

  // R14: detection condition select
  always_comb begin
    unique case (cur.cond)
      COND_APPROACH: det_raw = approach_detect;
      COND_LEAVE:    det_raw = leave_detect;
      default:       det_raw = approach_detect | leave_detect;
    endcase
  end

  // R15: inverse after judging
  assign det = det_raw ^ cur.inverse;

  // R9: percent of full scale, 0..100
  assign sens_prod = PROD_W'(sens_pin_level) * SENS_SCALE;

  // Arms a linear fade from the present duty toward a target
  function automatic ctrl_s start_fade(ctrl_s s, logic [6:0] target,
                                       logic [13:0] time_ms);
    ctrl_s r;
    r         = s;
    r.goal    = target;
    r.delta   = (s.duty > target) ? s.duty - target : target - s.duty;
    r.span    = time_ms;
    r.elapsed = '0;
    r.acc     = '0;
    if (time_ms == '0) begin
      r.duty = target;
    end
    return r;
  endfunction

  // R8: time values read back split into seven-bit halves
  function automatic logic [7:0] read_byte(ctrl_s s, logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_COND:        v = {6'h00, s.cond};
      ADDR_INVERSE:     v = {7'h00, s.inverse};
      ADDR_FREQ:        v = {4'h0, s.freq};
      ADDR_IDLE_DUTY:   v = {1'b0, s.idle_duty};
      ADDR_ACTIVE_DUTY: v = {1'b0, s.active_duty};
      ADDR_UP_HIGH:     v = {1'b0, s.ramp_up[TIME_W-1:LOW_W]};
      ADDR_UP_LOW:      v = {1'b0, s.ramp_up[LOW_W-1:0]};
      ADDR_DOWN_HIGH:   v = {1'b0, s.ramp_down[TIME_W-1:LOW_W]};
      ADDR_DOWN_LOW:    v = {1'b0, s.ramp_down[LOW_W-1:0]};
      ADDR_LINGER_HIGH: v = {1'b0, s.linger[TIME_W-1:LOW_W]};
      ADDR_LINGER_LOW:  v = {1'b0, s.linger[LOW_W-1:0]};
      ADDR_PIN_SENS:    v = {1'b0, s.pin_sens};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    logic [6:0] p;
    logic       bad;
    p   = cmd_byte[6:0];
    bad = 1'b0;
    next_cur            = cur;
    next_cur.resp_valid = 1'b0;
    next_cur.cmd_error  = 1'b0;

    // R11: refreshed regardless of the enable
    next_cur.pin_sens = sens_prod[PROD_W-1:PROD_W-DUTY_W];
    // R10: pin value feeds both directions
    next_cur.approach_sens =
      analog_sens_enable ? cur.pin_sens : manual_sensitivity;
    next_cur.leave_sens =
      analog_sens_enable ? cur.pin_sens : manual_sensitivity;
    // New slot width reaches the pin only at its next period start
    next_cur.step_cycles = step_tab[cur.freq];

    // R16: address byte first, then parameter byte
    if (cmd_valid) begin
      if ((cmd_byte & ADDR_FLAG) != 8'h00) begin
        next_cur.have_addr = 1'b1;
        next_cur.addr      = cmd_byte;
      end else if (!cur.have_addr) begin
        bad = 1'b1;
      end else begin
        next_cur.have_addr = 1'b0;
        unique case (cur.addr)
          ADDR_READ: begin
            next_cur.resp_valid = 1'b1;
            next_cur.resp_data  = read_byte(cur, {1'b1, p});
          end
          ADDR_COND:
            if (p[1:0] > COND_MAX || p[6:2] != '0) bad = 1'b1;
            else next_cur.cond = p[1:0];
          ADDR_INVERSE:
            if (p[6:1] != '0) bad = 1'b1;
            else next_cur.inverse = p[0];
          ADDR_FREQ:
            if (p[3:0] > FREQ_MAX || p[6:4] != '0) bad = 1'b1;
            else next_cur.freq = p[3:0];
          // R1: idle duty range
          ADDR_IDLE_DUTY:
            if (p > DUTY_MAX) bad = 1'b1;
            else next_cur.idle_duty = p;
          // R2: active duty range
          ADDR_ACTIVE_DUTY:
            if (p > DUTY_MAX) bad = 1'b1;
            else next_cur.active_duty = p;
          // R8: high half holds bits 13..7, low half bits 6..0
          ADDR_UP_HIGH:     next_cur.ramp_up[TIME_W-1:LOW_W]   = p;
          ADDR_UP_LOW:      next_cur.ramp_up[LOW_W-1:0]        = p;
          ADDR_DOWN_HIGH:   next_cur.ramp_down[TIME_W-1:LOW_W] = p;
          ADDR_DOWN_LOW:    next_cur.ramp_down[LOW_W-1:0]      = p;
          ADDR_LINGER_HIGH: next_cur.linger[TIME_W-1:LOW_W]    = p;
          ADDR_LINGER_LOW:  next_cur.linger[LOW_W-1:0]         = p;
          // R12: write to sensitivity status refused
          default: bad = 1'b1;
        endcase
      end
    end
    // A refused byte writes no setting; it raises the pulse and drops any held address
    next_cur.cmd_error = bad;

    // One step per clock: a tick must span more clocks than the
    // largest duty change, or a very short fade ends late
    // R17: drain whole percent steps owed by the accumulator
    if (cur.span != '0 && cur.duty != cur.goal &&
        cur.acc >= ACC_W'(cur.span)) begin
      next_cur.acc  = cur.acc - ACC_W'(cur.span);
      next_cur.duty = (cur.goal > cur.duty) ? cur.duty + 1'b1
                                            : cur.duty - 1'b1;
    end
    // R17: one millisecond of progress per tick
    if (ms_tick && cur.elapsed < cur.span) begin
      next_cur.elapsed = cur.elapsed + 1'b1;
      next_cur.acc     = next_cur.acc + ACC_W'(cur.delta);
    end

    unique case (cur.state)
      ST_IDLE: begin
        // R1: follows idle duty setting
        next_cur.duty = cur.idle_duty;
        if (det) begin
          // R4: fade in toward active duty
          next_cur       = start_fade(next_cur, cur.active_duty,
                                      cur.ramp_up);
          next_cur.state = ST_RAMP_UP;
        end
      end
      ST_RAMP_UP: begin
        // Losing detection mid-fade still completes the fade first
        if (cur.elapsed == cur.span && cur.duty == cur.goal) begin
          next_cur.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // R2: follows active duty setting
        next_cur.duty = cur.active_duty;
        if (!det) begin
          next_cur.state   = ST_LINGER;
          next_cur.ms_in_s = '0;
          next_cur.secs    = '0;
        end
      end
      ST_LINGER: begin
        // Ticks are gathered into whole seconds of hold
        next_cur.duty = cur.active_duty;
        if (ms_tick) begin
          if (cur.ms_in_s == LAST_MS) begin
            next_cur.ms_in_s = '0;
            next_cur.secs    = cur.secs + 1'b1;
          end else begin
            next_cur.ms_in_s = cur.ms_in_s + 1'b1;
          end
        end
        // R7: hold for programmed seconds
        if (det) begin
          next_cur.state = ST_ACTIVE;
        end else if (cur.secs >= cur.linger) begin
          // R6: fade out after the hold
          next_cur       = start_fade(next_cur, cur.idle_duty,
                                      cur.ramp_down);
          next_cur.state = ST_RAMP_DOWN;
        end
      end
      ST_RAMP_DOWN: begin
        if (det) begin
          // R4: renewed detection fades back in from here
          next_cur       = start_fade(next_cur, cur.active_duty,
                                      cur.ramp_up);
          next_cur.state = ST_RAMP_UP;
        end else if (cur.elapsed == cur.span && cur.duty == cur.goal) begin
          next_cur.state = ST_IDLE;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur             <= '0;
      cur.state       <= ST_IDLE;
      cur.idle_duty   <= IDLE_DUTY_RST;
      // R3: ninety percent
      cur.active_duty <= ACTIVE_DUTY_RST;
      // R5: one second fade in
      cur.ramp_up     <= RAMP_UP_RST;
      cur.ramp_down   <= RAMP_DOWN_RST;
      cur.linger      <= LINGER_RST;
      cur.freq        <= FREQ_RST;
      cur.cond        <= COND_BOTH;
      cur.duty        <= IDLE_DUTY_RST;
      cur.goal        <= IDLE_DUTY_RST;
      cur.step_cycles <= RST_STEP;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign resp_valid           = cur.resp_valid;
  assign resp_data            = cur.resp_data;
  assign cmd_error            = cur.cmd_error;
  assign current_duty         = cur.duty;
  assign approach_sensitivity = cur.approach_sens;
  assign leave_sensitivity    = cur.leave_sens;
endmodule

// ===== tb/pwm_fade_assertions.sv
// Purpose: Port checks for the detection PWM fade block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the bench, sees top ports only
`timescale 1ns/1ps
module pwm_fade_assertions
  import pwm_fade_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              ce,
  input wire logic              cmd_valid,
  input wire logic [7:0]        cmd_byte,
  input wire logic              pwm_mode,
  input wire logic              analog_sens_enable,
  input wire logic [ADC_W-1:0]  sens_pin_level,
  input wire logic [6:0]        manual_sensitivity,
  input wire logic              motion_output_pin,
  input wire logic              resp_valid,
  input wire logic              cmd_error,
  input wire logic [DUTY_W-1:0] current_duty,
  input wire logic [6:0]        approach_sensitivity,
  input wire logic [6:0]        leave_sensitivity
);
  logic [PROD_W-1:0] scaled;
  logic              par_t;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  assign scaled = PROD_W'(sens_pin_level) * SENS_SCALE;
  assign par_t  = ce && cmd_valid && !cmd_byte[7];

  sequence pair_s(logic [7:0] a);
    (ce && cmd_valid && cmd_byte == a) ##1 par_t;
  endsequence

  sequence duty_s(logic over);
    (ce && cmd_valid && cmd_byte == ADDR_ACTIVE_DUTY)
      ##1 (par_t && (cmd_byte[6:0] > DUTY_MAX) == over);
  endsequence

  chk_reset_quiet: assert property (
    $fell(reset) |-> current_duty == '0 && !resp_valid && !cmd_error)
    else $error("outputs busy after reset");
  chk_duty_range: assert property (
    current_duty <= DUTY_MAX)
    else $error("duty above full scale");
  chk_duty_taken: assert property (
    duty_s(1'h0) |=> !cmd_error)
    else $error("valid duty refused");
  chk_duty_refused: assert property (
    duty_s(1'h1) |=> cmd_error)
    else $error("oversized duty accepted");
  chk_read_answer: assert property (
    pair_s(ADDR_READ) |=> resp_valid)
    else $error("read without answer");
  chk_stray_value: assert property (
    par_t ##1 par_t |=> cmd_error)
    else $error("stray value byte accepted");
  chk_status_ro: assert property (
    pair_s(ADDR_PIN_SENS) |=> cmd_error)
    else $error("status write accepted");
  chk_pin_parked: assert property (
    (ce && !pwm_mode) [*2] |-> !motion_output_pin)
    else $error("pin active outside pwm mode");
  chk_pin_sens: assert property (
    (ce && analog_sens_enable && $stable(sens_pin_level)) [*4] |->
      approach_sensitivity == scaled[PROD_W-1:ADC_W] &&
      leave_sensitivity == scaled[PROD_W-1:ADC_W])
    else $error("pin sensitivity not applied");
  chk_manual_sens: assert property (
    (ce && !analog_sens_enable && $stable(manual_sensitivity)) [*4] |->
      approach_sensitivity == manual_sensitivity &&
      leave_sensitivity == manual_sensitivity)
    else $error("manual sensitivity not applied");
endmodule

// ===== tb/host_link_model.sv
// Purpose: Host side of the byte command link
// Assumes: Bytes change after the falling edge, one cycle each
// Notes:   A released byte line shows the inverse of its last byte
`timescale 1ns/1ps
module host_link_model (
  input  wire logic       clk,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data,
  input  wire logic       cmd_error,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte
);
  initial begin
    cmd_valid = 1'h0;
    cmd_byte  = 8'h00;
  end

  task automatic put(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_byte  = b;
  endtask

  task automatic release_link();
    @(negedge clk);
    cmd_valid = 1'h0;
    cmd_byte  = ~cmd_byte;
  endtask

  task automatic access(input logic [7:0] a, input logic [6:0] p,
                        output logic err, output logic [7:0] d);
    err = 1'h0;
    d   = 8'hXX;
    put(a);
    put({1'h0, p});
    release_link();
    repeat (3) begin
      if (cmd_error === 1'h1)
        err = 1'h1;
      if (resp_valid === 1'h1)
        d = resp_data;
      @(negedge clk);
    end
  endtask

  task automatic put_time(input logic [7:0] a, input logic [13:0] v);
    logic       e;
    logic [7:0] d;
    access(a, v[13:7], e, d);
    access(a + 8'h01, v[6:0], e, d);
  endtask
endmodule

// ===== tb/detection_pwm_fade_control_tb.sv
// Purpose: Self-checking bench for the detection PWM fade block
// Assumes: Twenty clocks stand for one millisecond
// Notes:   Register table first, then link, fade and pin cases
`timescale 1ns/1ps
module detection_pwm_fade_control_tb
  import pwm_fade_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [6:0] wdata;
    logic       err;
    logic [7:0] rd;
  } row_s;
  logic              clk = 1'h0, reset = 1'h1, ce = 1'h1;
  logic              pwm_mode = 1'h1, analog_sens_enable = 1'h0;
  logic              approach_detect = 1'h0, leave_detect = 1'h0;
  logic [ADC_W-1:0]  sens_pin_level = 12'hFFF;
  logic [6:0]        manual_sensitivity = 7'h00;
  logic              cmd_valid, resp_valid, cmd_error, motion_output_pin, e;
  logic [7:0]        cmd_byte, resp_data, d;
  logic [DUTY_W-1:0] current_duty;
  logic [6:0]        approach_sensitivity, leave_sensitivity;
  int                failures = 0, compares = 0, cycles = 0, highs;
  row_s rows [21] = '{
    '{8'hA4, 1'h0, 7'h00, 1'h0, 8'h00}, '{8'hA5, 1'h0, 7'h00, 1'h0, 8'h5A},
    '{8'hA6, 1'h0, 7'h00, 1'h0, 8'h07}, '{8'hA7, 1'h0, 7'h00, 1'h0, 8'h68},
    '{8'hA8, 1'h0, 7'h00, 1'h0, 8'h07}, '{8'hA9, 1'h0, 7'h00, 1'h0, 8'h68},
    '{8'hAA, 1'h0, 7'h00, 1'h0, 8'h00}, '{8'hAB, 1'h0, 7'h00, 1'h0, 8'h0A},
    '{8'hA0, 1'h0, 7'h00, 1'h0, 8'h00}, '{8'hA1, 1'h0, 7'h00, 1'h0, 8'h00},
    '{8'hA3, 1'h0, 7'h00, 1'h0, 8'h04}, '{8'h90, 1'h0, 7'h00, 1'h0, 8'h00},
    '{8'hA4, 1'h1, 7'h64, 1'h0, 8'h64}, '{8'hA4, 1'h1, 7'h65, 1'h1, 8'h64},
    '{8'hA5, 1'h1, 7'h00, 1'h0, 8'h00}, '{8'hA5, 1'h1, 7'h65, 1'h1, 8'h00},
    '{8'hA0, 1'h1, 7'h03, 1'h1, 8'h00}, '{8'hA1, 1'h1, 7'h02, 1'h1, 8'h00},
    '{8'hA3, 1'h1, 7'h0A, 1'h1, 8'h04}, '{8'hA3, 1'h1, 7'h09, 1'h0, 8'h09},
    '{8'hB0, 1'h1, 7'h11, 1'h1, 8'h64}
  };

  detection_pwm_fade_control #(.TICK_CYCLES(20)) dut_u (.*);
  host_link_model host_u (.*);

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run needs about 41000 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] got, want, input string m);
    compares++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, want, input string m);
    host_u.access(ADDR_READ, a[6:0], e, d);
    check(d, want, m);
  endtask

  task automatic duty(input logic [7:0] want, input string m);
    check({1'h0, current_duty}, want, m);
  endtask

  initial begin
    cyc(3);
    reset = 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        host_u.access(rows[i].addr, rows[i].wdata, e, d);
        check({7'h00, e}, {7'h00, rows[i].err}, $sformatf("st %0d", i));
      end
      rd(rows[i].addr, rows[i].rd, $sformatf("row %0d", i));
    end
    host_u.put(ADDR_IDLE_DUTY);
    host_u.put(ADDR_ACTIVE_DUTY);
    host_u.put(8'h11);
    host_u.put(8'h12);
    host_u.release_link();
    check({7'h00, cmd_error}, 8'h01, "stray byte taken");
    rd(ADDR_ACTIVE_DUTY, 8'h11, "new address lost");
    rd(ADDR_IDLE_DUTY, 8'h64, "old address written");
    analog_sens_enable = 1'h1;
    sens_pin_level = 12'h800;
    cyc(6);
    check({1'h0, approach_sensitivity}, 8'h32, "approach sens");
    check({1'h0, leave_sensitivity}, 8'h32, "leave sens");
    analog_sens_enable = 1'h0;
    manual_sensitivity = 7'h11;
    sens_pin_level = 12'h400;
    cyc(6);
    check({1'h0, approach_sensitivity}, 8'h11, "manual sens");
    check({1'h0, leave_sensitivity}, 8'h11, "manual leave");
    rd(ADDR_PIN_SENS, 8'h19, "status stale");
    host_u.access(ADDR_IDLE_DUTY, 7'h0A, e, d);
    host_u.access(ADDR_ACTIVE_DUTY, 7'h14, e, d);
    host_u.put_time(ADDR_UP_HIGH, 14'h000A);
    host_u.put_time(ADDR_DOWN_HIGH, 14'h0005);
    host_u.put_time(ADDR_LINGER_HIGH, 14'h0001);
    rd(ADDR_UP_LOW, 8'h0A, "split time");
    duty(8'h0A, "idle duty");
    approach_detect = 1'h1;
    cyc(100);
    compares++;
    if (current_duty !== 7'h0E && current_duty !== 7'h0F) begin
      failures++;
      $display("CHECK FAILED t=%0t fade midpoint", $time);
    end
    cyc(110);
    duty(8'h14, "fade in end");
    approach_detect = 1'h0;
    cyc(19700);
    duty(8'h14, "hold too short");
    cyc(600);
    duty(8'h0A, "fade out end");
    host_u.put_time(ADDR_UP_HIGH, 14'h0000);
    host_u.put_time(ADDR_DOWN_HIGH, 14'h0000);
    host_u.put_time(ADDR_LINGER_HIGH, 14'h0000);
    host_u.access(ADDR_COND, 7'h01, e, d);
    leave_detect = 1'h1;
    cyc(10);
    duty(8'h0A, "leave seen as approach");
    host_u.access(ADDR_COND, 7'h02, e, d);
    cyc(10);
    duty(8'h14, "leave not judged");
    leave_detect = 1'h0;
    cyc(10);
    duty(8'h0A, "zero hold");
    host_u.access(ADDR_INVERSE, 7'h01, e, d);
    cyc(10);
    duty(8'h14, "inverse ignored");
    host_u.access(ADDR_INVERSE, 7'h00, e, d);
    host_u.access(ADDR_IDLE_DUTY, 7'h64, e, d);
    cyc(20100);
    highs = 0;
    repeat (50) begin
      @(negedge clk);
      highs += int'(motion_output_pin === 1'h1);
    end
    check(8'(highs), 8'h32, "full duty pin");
    pwm_mode = 1'h0;
    cyc(3);
    check({7'h00, motion_output_pin}, 8'h00, "pin not parked");
    reset = 1'h1;
    cyc(3);
    reset = 1'h0;
    rd(ADDR_ACTIVE_DUTY, 8'h5A, "active reset");
    rd(ADDR_UP_HIGH, 8'h07, "fade in reset");
    rd(ADDR_LINGER_LOW, 8'h0A, "hold reset");
    report_and_stop();
  end
endmodule

bind detection_pwm_fade_control pwm_fade_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_u (.*);
